// ---- design/parallel_byte_fifo_port.sv ----
// Byte-wide parallel FIFO port toward an external controller
`timescale 1ns/1ps
`include "fifo_port_defs.svh"
// Summary of operation
// - rx_avail_n goes low while a receive byte is ready to fetch.
// - tx_space_n goes low only when the transmit buffer can take a byte.
// - The current receive byte is driven on the bus only while the read strobe is low.
// - The rising edge of the read strobe advances to the next receive byte.
// - The falling edge of the write strobe stores the bus byte into the transmit buffer.
// - power_on_n is high in suspend and low in normal operation.
// - In suspend with wake-up enabled, a low pulse on send_now_wake_n requests resume.
// - In normal operation, a low pulse on send_now_wake_n flushes the transmit buffer.
// - The two status outputs are undriven during reset.
// - A configuration bit selects pull-low instead of pull-up on bus inputs in suspend.
// - After a read the receive status stays inactive at least 80 ns.
// - After a write the transmit status stays inactive at least 80 ns.
module parallel_byte_fifo_port #(
   parameter int GAP_CYC = `GAP_CYCLES
) (
   input wire logic clk_i,
   input wire logic reset_n_i,
   // USB-side receive stream in
   input wire logic rx_valid_i,
   output logic rx_ready_o,
   input wire logic [`BYTE_W-1:0] rx_data_i,
   // USB-side transmit stream out
   output logic tx_valid_o,
   input wire logic tx_ready_i,
   output logic [`BYTE_W-1:0] tx_data_o,
   output logic tx_flush_o,
   // USB state
   input wire logic suspended_i,
   input wire logic wake_enable_i,
   input wire logic pull_low_cfg_i,
   output logic resume_req_o,
   output logic bus_pull_low_o,
   // Controller pins
   input wire logic rd_n_i,
   input wire logic wr_i,
   input wire logic send_now_wake_n_i,
   input wire logic [`BYTE_W-1:0] fifo_byte_bus_i,
   output fifo_port_pkg::byte_t fifo_byte_bus_o,
   output logic fifo_byte_bus_oe_n_o,
   output logic rx_avail_n_o,
   output logic rx_avail_oe_n_o,
   output logic tx_space_n_o,
   output logic tx_space_oe_n_o,
   output logic power_on_n_o
);
   import fifo_port_pkg::*;

   typedef struct packed {
      logic [2:0] rd_sync;
      logic [2:0] wr_sync;
      logic [2:0] si_sync;
      rd_state_t rd_st;
      wr_state_t wr_st;
      logic [`GAP_CNT_W-1:0] rd_cnt;
      logic [`GAP_CNT_W-1:0] wr_cnt;
      byte_t rx_byte;
      logic rx_full;
      byte_t wr_byte;
      logic wr_pend;
      logic flush;
      logic resume;
      logic pwr_n;
      logic pull_low;
      logic drive;
   } port_state_t;

   port_state_t s_q, s_d;
   // Reset synchroniser sits apart: it runs on the raw reset, the rest on its copy
   logic [1:0] rst_sync_q;
   logic rst_n;
   logic rd_rise, rd_fall, wr_fall, si_fall;
   logic txb_ready;
   localparam logic [`GAP_CNT_W-1:0] GAP_LOAD = `GAP_CNT_W'(GAP_CYC);

   // Released reset copy; async assert only loads constants
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   // edge detect on second and third stages only
   assign rd_rise = s_q.rd_sync[1] && !s_q.rd_sync[2];
   assign rd_fall = !s_q.rd_sync[1] && s_q.rd_sync[2];
   assign wr_fall = !s_q.wr_sync[1] && s_q.wr_sync[2];
   assign si_fall = !s_q.si_sync[1] && s_q.si_sync[2];

   // Transmit path buffer so a stalled USB side loses no byte
   skid_buffer #(.WIDTH(`BYTE_W)) u_tx_buf (
      .clk_i(clk_i),
      .rst_n_i(rst_n),
      .in_valid_i(s_q.wr_pend),
      .in_ready_o(txb_ready),
      .in_data_i(s_q.wr_byte),
      .out_valid_o(tx_valid_o),
      .out_ready_i(tx_ready_i),
      .out_data_o(tx_data_o)
   );

   // Next-state logic for both strobe sides
   always_comb begin
      s_d = s_q;
      s_d.rd_sync = {s_q.rd_sync[1:0], rd_n_i};
      s_d.wr_sync = {s_q.wr_sync[1:0], wr_i};
      s_d.si_sync = {s_q.si_sync[1:0], send_now_wake_n_i};
      s_d.flush = 1'b0;
      s_d.resume = 1'b0;
      s_d.pwr_n = suspended_i;
      // pull direction chosen by config while suspended
      s_d.pull_low = suspended_i && pull_low_cfg_i;
      // wake request only in suspend with wake-up enabled
      if (si_fall && suspended_i && wake_enable_i) begin
         s_d.resume = 1'b1;
      end
      if (si_fall && !suspended_i) begin
         s_d.flush = 1'b1;
      end
      // Load a receive byte when the holding slot is free
      if (!s_q.rx_full && rx_valid_i && s_q.rd_st == RD_IDLE) begin
         s_d.rx_byte = rx_data_i;
         s_d.rx_full = 1'b1;
      end
      case (s_q.rd_st)
         RD_IDLE: begin
            if (rd_fall && s_q.rx_full) begin
               s_d.rd_st = RD_LOW;
            end
         end
         RD_LOW: begin
            // rising edge consumes the current byte
            if (rd_rise) begin
               s_d.rx_full = 1'b0;
               s_d.rd_cnt = GAP_LOAD;
               s_d.rd_st = RD_GAP;
            end
         end
         RD_GAP: begin
            // hold status inactive for the gap
            if (s_q.rd_cnt <= `GAP_CNT_W'(1)) begin
               s_d.rd_st = RD_IDLE;
            end else begin
               s_d.rd_cnt = s_q.rd_cnt - `GAP_CNT_W'(1);
            end
         end
         default: s_d.rd_st = RD_IDLE;
      endcase
      // drive bus while the read strobe is low (synchronised view)
      // The second and third stages are read; the first may still be settling
      s_d.drive = !s_q.rd_sync[1] && (s_q.rd_st == RD_LOW || (rd_fall && s_q.rx_full));
      if (s_q.wr_pend && txb_ready) begin
         s_d.wr_pend = 1'b0;
      end
      case (s_q.wr_st)
         WR_IDLE: begin
            // falling edge captures the bus byte
            if (wr_fall && !s_q.wr_pend) begin
               s_d.wr_byte = fifo_byte_bus_i;
               s_d.wr_pend = 1'b1;
               s_d.wr_cnt = GAP_LOAD;
               s_d.wr_st = WR_GAP;
            end else if (s_q.wr_sync[1]) begin
               s_d.wr_st = WR_HIGH;
            end
         end
         WR_HIGH: begin
            if (wr_fall && !s_q.wr_pend) begin
               s_d.wr_byte = fifo_byte_bus_i;
               s_d.wr_pend = 1'b1;
               s_d.wr_cnt = GAP_LOAD;
               s_d.wr_st = WR_GAP;
            end
         end
         WR_GAP: begin
            // hold transmit status inactive for the gap
            if (s_q.wr_cnt <= `GAP_CNT_W'(1)) begin
               s_d.wr_st = WR_IDLE;
            end else begin
               s_d.wr_cnt = s_q.wr_cnt - `GAP_CNT_W'(1);
            end
         end
         default: s_d.wr_st = WR_IDLE;
      endcase
   end

   // Main state register; the reset synchroniser has its own process above
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         s_q.rd_sync <= 3'h7;
         s_q.wr_sync <= 3'h0;
         s_q.si_sync <= 3'h7;
         s_q.rd_st <= RD_IDLE;
         s_q.wr_st <= WR_IDLE;
         s_q.rd_cnt <= '0;
         s_q.wr_cnt <= '0;
         s_q.rx_byte <= 8'h00;
         s_q.rx_full <= 1'b0;
         s_q.wr_byte <= 8'h00;
         s_q.wr_pend <= 1'b0;
         s_q.flush <= 1'b0;
         s_q.resume <= 1'b0;
         s_q.pwr_n <= 1'b0;
         s_q.pull_low <= 1'b0;
         s_q.drive <= 1'b0;
      end else begin
         s_q.rd_sync <= s_d.rd_sync;
         s_q.wr_sync <= s_d.wr_sync;
         s_q.si_sync <= s_d.si_sync;
         s_q.rd_st <= s_d.rd_st;
         s_q.wr_st <= s_d.wr_st;
         s_q.rd_cnt <= s_d.rd_cnt;
         s_q.wr_cnt <= s_d.wr_cnt;
         s_q.rx_byte <= s_d.rx_byte;
         s_q.rx_full <= s_d.rx_full;
         s_q.wr_byte <= s_d.wr_byte;
         s_q.wr_pend <= s_d.wr_pend;
         s_q.flush <= s_d.flush;
         s_q.resume <= s_d.resume;
         s_q.pwr_n <= s_d.pwr_n;
         s_q.pull_low <= s_d.pull_low;
         s_q.drive <= s_d.drive;
      end
   end

   // receive status low while a byte is held and no read in flight
   assign rx_avail_n_o = !(s_q.rx_full && s_q.rd_st == RD_IDLE);
   // transmit status low only with room and outside the gap
   assign tx_space_n_o = !(s_q.wr_st != WR_GAP && !s_q.wr_pend && txb_ready);
   // status pins released while in reset
   assign rx_avail_oe_n_o = !rst_n;
   assign tx_space_oe_n_o = !rst_n;
   assign fifo_byte_bus_o = s_q.rx_byte;
   assign fifo_byte_bus_oe_n_o = !s_q.drive;
   assign rx_ready_o = !s_q.rx_full && s_q.rd_st == RD_IDLE;
   assign tx_flush_o = s_q.flush;
   assign resume_req_o = s_q.resume;
   assign power_on_n_o = s_q.pwr_n;
   assign bus_pull_low_o = s_q.pull_low;

   // a_rx_gap: receive status stays high through the gap
   a_rx_gap_hold: assert property (@(posedge clk_i) disable iff (!rst_n)
      (s_q.rd_st == RD_LOW && rd_rise) |=> rx_avail_n_o [*2])
      else $error("receive status active too soon after read");
   a_tx_gap_hold: assert property (@(posedge clk_i) disable iff (!rst_n)
      (wr_fall && !s_q.wr_pend && s_q.wr_st != WR_GAP) |=> tx_space_n_o [*2])
      else $error("transmit status active too soon after write");
   a_rx_avail_set: assert property (@(posedge clk_i) disable iff (!rst_n)
      (rx_valid_i && rx_ready_o) |=> !rx_avail_n_o)
      else $error("byte taken but receive status inactive");
   a_tx_space_room: assert property (@(posedge clk_i) disable iff (!rst_n)
      !tx_space_n_o |-> txb_ready && !s_q.wr_pend)
      else $error("transmit status active without room");
   a_bus_drive_rd: assert property (@(posedge clk_i) disable iff (!rst_n)
      !fifo_byte_bus_oe_n_o |-> !s_q.rd_sync[2] || !$past(s_q.rd_sync[1]))
      else $error("bus driven while read strobe high");
   a_rd_advance: assert property (@(posedge clk_i) disable iff (!rst_n)
      (s_q.rd_st == RD_LOW && rd_rise) |=> !s_q.rx_full)
      else $error("read edge did not advance");
   a_wr_capture: assert property (@(posedge clk_i) disable iff (!rst_n)
      (wr_fall && !s_q.wr_pend && s_q.wr_st != WR_GAP) |=>
      s_q.wr_pend && s_q.wr_byte == $past(fifo_byte_bus_i))
      else $error("write edge did not capture bus byte");
   a_pwr_level: assert property (@(posedge clk_i) disable iff (!rst_n)
      ##1 power_on_n_o == $past(suspended_i))
      else $error("power_on_n does not follow suspend");
   a_wake_req: assert property (@(posedge clk_i) disable iff (!rst_n)
      (si_fall && suspended_i && wake_enable_i) |=> resume_req_o)
      else $error("no resume request on wake pulse");
   a_flush_req: assert property (@(posedge clk_i) disable iff (!rst_n)
      (si_fall && !suspended_i) |=> tx_flush_o && !resume_req_o)
      else $error("no flush on send pulse");

   c_read_done: cover property (@(posedge clk_i) disable iff (!rst_n)
      s_q.rd_st == RD_LOW ##[1:20] s_q.rd_st == RD_GAP);
   c_write_done: cover property (@(posedge clk_i) disable iff (!rst_n)
      s_q.wr_st == WR_GAP ##[1:20] tx_valid_o);
   c_tx_stall: cover property (@(posedge clk_i) disable iff (!rst_n) !txb_ready);
   c_wake: cover property (@(posedge clk_i) disable iff (!rst_n) resume_req_o);
endmodule

// ---- pkg/fifo_port_defs.svh ----
// Timing counts and widths for the parallel byte FIFO port
`ifndef FIFO_PORT_DEFS_SVH
`define FIFO_PORT_DEFS_SVH
`define CLK_PERIOD_NS 40
`define GAP_TIME_NS 80
`define GAP_CYCLES ((`GAP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define GAP_CNT_W 4
`define BYTE_W 8
`endif

// ---- pkg/fifo_port_pkg.sv ----
// Types shared by the parallel byte FIFO port
package fifo_port_pkg;
   typedef logic [7:0] byte_t;
   // Read-side states, one bit apart except RD_GAP back to RD_IDLE
   typedef enum logic [1:0] {
      RD_IDLE = 2'b00,
      RD_LOW = 2'b01,
      RD_GAP = 2'b11
   } rd_state_t;
   // Write-side states; WR_IDLE and WR_GAP differ in both bits
   typedef enum logic [1:0] {
      WR_IDLE = 2'b00,
      WR_HIGH = 2'b01,
      WR_GAP = 2'b11
   } wr_state_t;
endpackage

// ---- design/skid_buffer.sv ----
// Two-entry valid/ready buffer
`timescale 1ns/1ps
module skid_buffer #(
   parameter int WIDTH = 8
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   typedef struct packed {
      logic [1:0][WIDTH-1:0] mem;
      logic wp;
      logic rp;
      logic [1:0] cnt;
   } sb_state_t;
   sb_state_t s_q, s_d;
   logic push, pop;

   // Handshakes; full refuses pushes so a stalled sink loses nothing
   assign in_ready_o = (s_q.cnt != 2'h2);
   assign out_valid_o = (s_q.cnt != 2'h0);
   assign out_data_o = s_q.mem[s_q.rp];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   // Next state
   always_comb begin
      s_d = s_q;
      if (push) begin
         s_d.mem[s_q.wp] = in_data_i;
         s_d.wp = ~s_q.wp;
      end
      if (pop) begin
         s_d.rp = ~s_q.rp;
      end
      s_d.cnt = s_q.cnt + {1'b0, push} - {1'b0, pop};
   end

   // State register
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // A full buffer facing a stalled sink must keep both words intact
   a_no_overflow: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (s_q.cnt == 2'h2 && !out_ready_i) |=> s_q.mem == $past(s_q.mem))
      else $error("buffer word overwritten while full");
endmodule

// ---- test/fifo_ctrl_model.sv ----
// External controller model that strobes the parallel FIFO port
`timescale 1ns/1ps
module fifo_ctrl_model (
   input wire logic clk_i,
   input wire logic rx_avail_n_i,
   input wire logic tx_space_n_i,
   input wire logic [7:0] bus_i,
   output logic rd_n_o,
   output logic wr_o,
   output logic wake_n_o,
   output logic drive_o,
   output logic [7:0] data_o
);
   // Idle pin levels; the data lines start released
   initial begin
      rd_n_o = 1'b1;
      wr_o = 1'b0;
      wake_n_o = 1'b1;
      drive_o = 1'b0;
      data_o = 8'h00;
   end

   // Bounded wait on an active-low status line
   task automatic wait_low(input bit rx, output bit ok);
      int i;
      i = 0;
      while ((rx ? rx_avail_n_i : tx_space_n_i) !== 1'b0 && i < 100) begin
         @(posedge clk_i);
         i++;
      end
      ok = (i < 100);
   endtask

   // read only when data, strobe low then high
   task automatic read_byte(output logic [7:0] b, output bit ok);
      wait_low(1'b1, ok);
      b = 8'h00;
      if (ok) begin
         rd_n_o <= 1'b0;
         repeat (5) @(posedge clk_i);
         b = bus_i;
         rd_n_o <= 1'b1;
         repeat (3) @(posedge clk_i);
      end
   endtask

   // write only with room, strobe high then low with data held
   task automatic write_byte(input logic [7:0] b, output bit ok);
      wait_low(1'b0, ok);
      if (ok) begin
         data_o <= b;
         drive_o <= 1'b1;
         wr_o <= 1'b1;
         repeat (3) @(posedge clk_i);
         wr_o <= 1'b0;
         // Data kept past the synchronised capture point
         repeat (4) @(posedge clk_i);
         drive_o <= 1'b0;
      end
   endtask

   // Low pulse long enough to pass the synchroniser
   task automatic wake_pulse();
      wake_n_o <= 1'b0;
      repeat (4) @(posedge clk_i);
      wake_n_o <= 1'b1;
      @(posedge clk_i);
   endtask
endmodule

// ---- test/testbench.sv ----
// Self-checking bench for the parallel byte FIFO port
`timescale 1ns/1ps
module testbench;
   import fifo_port_pkg::*;
   logic clk, reset_n, rx_valid, tx_ready, susp, wake_en, pl_cfg;
   logic rx_ready, tx_valid, tx_flush, resume_req, pull_low, bus_oe_n;
   logic rx_av_n, rx_av_oe_n, tx_sp_n, tx_sp_oe_n, pwr_n;
   logic rd_n, wr, wake_n, drive;
   logic [7:0] rx_data, tx_data, ctl_data, bus;
   byte_t bus_out;
   int err_count, num_checks, n_flush, n_res;
   logic [7:0] txq[$];

   // Released lines follow the weak pull chosen by the port
   assign bus = !bus_oe_n ? bus_out : drive ? ctl_data : {8{!pull_low}};

   parallel_byte_fifo_port #(.GAP_CYC(2)) uut (
      .clk_i(clk), .reset_n_i(reset_n),
      .rx_valid_i(rx_valid), .rx_ready_o(rx_ready), .rx_data_i(rx_data),
      .tx_valid_o(tx_valid), .tx_ready_i(tx_ready), .tx_data_o(tx_data),
      .tx_flush_o(tx_flush), .suspended_i(susp), .wake_enable_i(wake_en),
      .pull_low_cfg_i(pl_cfg), .resume_req_o(resume_req),
      .bus_pull_low_o(pull_low), .rd_n_i(rd_n), .wr_i(wr),
      .send_now_wake_n_i(wake_n), .fifo_byte_bus_i(bus),
      .fifo_byte_bus_o(bus_out), .fifo_byte_bus_oe_n_o(bus_oe_n),
      .rx_avail_n_o(rx_av_n), .rx_avail_oe_n_o(rx_av_oe_n),
      .tx_space_n_o(tx_sp_n), .tx_space_oe_n_o(tx_sp_oe_n),
      .power_on_n_o(pwr_n)
   );

   fifo_ctrl_model ctl (
      .clk_i(clk), .rx_avail_n_i(rx_av_n), .tx_space_n_i(tx_sp_n),
      .bus_i(bus), .rd_n_o(rd_n), .wr_o(wr), .wake_n_o(wake_n),
      .drive_o(drive), .data_o(ctl_data)
   );

   initial clk = 1'b0;
   always #20 clk = ~clk;

   // Pulse counters and transmit sink log
   always @(posedge clk) begin
      if (tx_flush === 1'b1) n_flush++;
      if (resume_req === 1'b1) n_res++;
      if (tx_valid === 1'b1 && tx_ready === 1'b1) txq.push_back(tx_data);
   end

   task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic stop_test();
      $display("Checks %0d, mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   // Offer one byte on the USB receive side, held until taken
   task automatic push(input logic [7:0] d);
      int i;
      @(posedge clk);
      rx_valid <= 1'b1;
      rx_data <= d;
      i = 0;
      do begin
         @(posedge clk);
         i++;
      end while (rx_ready !== 1'b1 && i < 100);
      check("rx_taken", rx_ready, 1);
      rx_valid <= 1'b0;
   endtask

   // Two bytes read back to back; the second waits behind the first
   task automatic t_rx();
      logic [7:0] b;
      bit ok;
      check("rx_empty", rx_av_n, 1);
      push(8'hA5);
      fork
         push(8'h3C);
      join_none
      repeat (3) @(posedge clk);
      check("rx_avail", rx_av_n, 0);
      ctl.read_byte(b, ok);
      check("rx_ok0", ok, 1);
      check("rx_byte0", b, 8'hA5);
      check("rx_gap0", rx_av_n, 1);
      @(posedge clk);
      check("rx_gap1", rx_av_n, 1);
      ctl.read_byte(b, ok);
      check("rx_ok", ok, 1);
      check("rx_byte1", b, 8'h3C);
      repeat (6) @(posedge clk);
      check("rx_drained", rx_av_n, 1);
      check("bus_free", bus_oe_n, 1);
   endtask

   // Fill the transmit path with the sink stalled, then drain it
   task automatic t_tx();
      int n;
      bit ok;
      tx_ready <= 1'b0;
      n = 0;
      while (n < 5) begin
         ctl.write_byte(8'h10 + n[7:0], ok);
         check("tx_ok", ok, 1);
         n++;
         @(posedge clk);
         check("tx_gap", tx_sp_n, 1);
         repeat (4) @(posedge clk);
         if (tx_sp_n !== 1'b0) break;
      end
      check("tx_depth", n >= 2, 1);
      check("tx_full", tx_sp_n, 1);
      tx_ready <= 1'b1;
      repeat (12) @(posedge clk);
      check("tx_count", txq.size(), n);
      for (int i = 0; i < n && i < txq.size(); i++) begin
         check("tx_byte", txq[i], 8'h10 + i);
      end
      check("tx_room", tx_sp_n, 0);
   endtask

   // Wake pin in all suspend and enable combinations
   task automatic t_wake();
      for (int i = 0; i < 4; i++) begin
         susp <= i[1];
         wake_en <= i[0];
         pl_cfg <= i[0];
         repeat (3) @(posedge clk);
         check("power_on_n", pwr_n, i[1]);
         check("pull_low", pull_low, i[1] & i[0]);
         n_flush = 0;
         n_res = 0;
         ctl.wake_pulse();
         repeat (6) @(posedge clk);
         check("flush", n_flush, !i[1]);
         check("resume", n_res, i[1] & i[0]);
      end
      susp <= 1'b0;
   endtask

   // Main sequence: inputs at time zero, reset, scenarios
   initial begin
      reset_n = 1'b0;
      rx_valid = 1'b0;
      rx_data = 8'h00;
      tx_ready = 1'b1;
      susp = 1'b0;
      wake_en = 1'b0;
      pl_cfg = 1'b0;
      repeat (5) @(posedge clk);
      check("rx_oe_rst", rx_av_oe_n, 1);
      check("tx_oe_rst", tx_sp_oe_n, 1);
      check("bus_oe_rst", bus_oe_n, 1);
      reset_n <= 1'b1;
      repeat (6) @(posedge clk);
      check("rx_oe_run", rx_av_oe_n, 0);
      check("tx_oe_run", tx_sp_oe_n, 0);
      t_rx();
      t_tx();
      t_wake();
      stop_test();
   end

   // Watchdog well beyond the expected run length
   initial begin
      #(40 * 20000);
      err_count++;
      stop_test();
   end
endmodule
